// file: hdl/audio_codec_control_regs.sv
// audio codec control and status register bank with input level control
// Behaviour
// - power-save floats positive, holds negative at mid
// - chip reset release clears speaker amp power
// - seven mute bits, one mutes, reset muted
// - mono gain three bits, reset 000
// - aux and line gains five bits, reset 08H
// - boost bit resets clear; pga level resets 08H
// - soft silence mutes dac independent of attenuation
// - dac attenuations seven bits, reset 00H
// - link mode: left write drives both channels
// - aux record off, pga record on at reset
// - power-down field reset 0000011; ready flags readable
// - rate codes apply only with variable rate
// - beep paths stay connected without beep power
// - mic bias only with mic block powered
// - mono2 floats unpowered; signal or common voltage
// - recovery never exceeds ceiling
// - recovery step one or two codes
// - limiter lowers by step count, clips at 00H
// - zero cross waits or timeout; disabled immediate
// - recovery wait and limiter period timing
// - jack irq drives active-low pin when enabled
`timescale 1ns/10ps
`default_nettype none
module audio_codec_control_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // chip reset pin
  input wire logic chip_reset_n,
  // register access from the link
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // analogue status in
  input wire logic vref_ready,
  input wire logic mixer_ready,
  input wire logic dac_ready,
  input wire logic adc_ready,
  input wire logic jack_event,
  input wire logic level_over,
  input wire logic zero_cross,
  // pin controls
  output logic spk_pos_pin_oe,
  output logic spk_neg_pin_mid,
  output logic mono2_pin_oe,
  output logic mono2_pin_common_voltage,
  output logic irq_out_n,
  // derived controls
  output logic dac_soft_silence,
  output logic [6:0] dac_left_atten_eff,
  output logic [6:0] dac_right_atten_eff,
  output logic beep_to_hp,
  output logic beep_to_spk,
  output logic int_mic_bias,
  output logic ext_mic_bias,
  output logic pll_power,
  output logic [15:0] dac_rate_eff,
  output logic [15:0] adc_rate_eff,
  output logic [5:0] input_pga_level
);
  import codec_regs_pkg::*;

  typedef enum logic {
    LV_IDLE = 1'b0,
    LV_WAIT_ZC = 1'b1
  } lvl_state_type;

  logic [15:0] spk_reg;
  logic [15:0] hp_reg;
  logic [15:0] mono_reg;
  logic [15:0] bass_reg;
  logic [15:0] beep_reg;
  logic [15:0] aux_reg;
  logic [15:0] mic_reg;
  logic [15:0] line_reg;
  logic [15:0] dac_reg;
  logic [15:0] rec_reg;
  logic [15:0] gp_reg;
  logic [15:0] pwrdn_reg;
  logic [15:0] ext_reg;
  logic [15:0] dac_rate_reg;
  logic [15:0] adc_rate_reg;
  logic [15:0] apwr_reg;
  logic [15:0] route_reg;
  logic [15:0] lvl_dac_reg;
  logic [15:0] lvl_mode_reg;
  logic [15:0] mixvol_reg;
  logic [2:0] rst_pin_sync_reg;
  logic pin_high_reg;
  logic [2:0] jack_sync_reg;
  logic jack_seen_reg;
  logic [15:0] fs_cnt_reg;
  logic half_fs_tick;
  lvl_state_type lvl_state_reg;
  logic [5:0] pga_target_reg;
  logic [12:0] quiet_cnt_reg;
  logic [12:0] zc_cnt_reg;
  logic [3:0] per_cnt_reg;
  logic pin_rise;
  logic lvl_en, zc_off, recov_start, lim_start, lvl_apply, zc_to;
  logic [5:0] pga_now, ceiling, lim_steps, recov_next, lim_next;
  logic [12:0] wait_lim, zc_lim;
  logic [3:0] per_lim;

  // write helper keeps unassigned bits at zero
  function automatic logic [15:0] wmask(input logic [15:0] d,
                                        input logic [15:0] m);
    return d & m;
  endfunction

  // widen before comparing so a step near the top cannot wrap
  function automatic logic [5:0] step_up(input logic [5:0] g,
                                         input logic [5:0] c,
                                         input logic two);
    logic [6:0] s;
    s = {1'b0, g} + (two ? 7'h02 : 7'h01);
    if (g >= c) begin
      return g;
    end
    return (s > {1'b0, c}) ? c : s[5:0];
  endfunction

  // half sample-period enable for level control timing
  assign half_fs_tick = (fs_cnt_reg == 16'(FS_HALF_CYC - 1));
  always_ff @(posedge clk_sys) begin
    if (rst || half_fs_tick) begin
      fs_cnt_reg <= 16'h0000;
    end else begin
      fs_cnt_reg <= fs_cnt_reg + 16'h0001;
    end
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rst_pin_sync_reg <= 3'h0;
      jack_sync_reg <= 3'h0;
      jack_seen_reg <= 1'b0;
      pin_high_reg <= 1'b0;
    end else begin
      rst_pin_sync_reg <= {rst_pin_sync_reg[1:0], chip_reset_n};
      jack_sync_reg <= {jack_sync_reg[1:0], jack_event};
      if (rst_pin_sync_reg[2] == rst_pin_sync_reg[1]) begin
        pin_high_reg <= rst_pin_sync_reg[1];
      end
      if (jack_sync_reg[2] == jack_sync_reg[1]) begin
        jack_seen_reg <= jack_sync_reg[1];
      end
    end
  end
  assign pin_rise = !pin_high_reg && rst_pin_sync_reg[2]
                    && rst_pin_sync_reg[1];

  // register writes; chip reset pin low holds defaults
  always_ff @(posedge clk_sys) begin
    if (rst || !pin_high_reg) begin
      spk_reg <= RST_SPK;
      hp_reg <= RST_HP;
      mono_reg <= RST_MONO;
      bass_reg <= RST_BASS;
      beep_reg <= RST_BEEP;
      aux_reg <= RST_AUX;
      line_reg <= RST_LINE;
      dac_reg <= RST_DAC;
      rec_reg <= RST_REC;
      gp_reg <= RST_GP;
      pwrdn_reg <= RST_PWRDN;
      ext_reg <= RST_EXT;
      dac_rate_reg <= RST_RATE;
      adc_rate_reg <= RST_RATE;
      apwr_reg <= RST_APWR;
      route_reg <= RST_ROUTE;
      lvl_dac_reg <= RST_LVL_DAC;
      lvl_mode_reg <= RST_LVL_MODE;
      mixvol_reg <= RST_MIXVOL;
    end else if (pin_rise) begin
      apwr_reg[B_SPK_AMP] <= 1'b0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFF_SPK: spk_reg <= wmask(reg_wdata, MASK_SPK);
        OFF_HP: hp_reg <= wmask(reg_wdata, MASK_HP);
        OFF_MONO: mono_reg <= wmask(reg_wdata, MASK_MONO);
        OFF_BASS: bass_reg <= wmask(reg_wdata, MASK_BASS);
        OFF_BEEP: beep_reg <= wmask(reg_wdata, MASK_BEEP);
        OFF_AUX: aux_reg <= wmask(reg_wdata, MASK_AUX);
        OFF_LINE: line_reg <= wmask(reg_wdata, MASK_LINE);
        OFF_DAC: begin
          dac_reg <= wmask(reg_wdata, MASK_DAC);
          // linked mode leaves the stored right field alone
          if (lvl_dac_reg[B_LINK]) begin
            dac_reg[6:0] <= dac_reg[6:0];
          end
        end
        OFF_REC: rec_reg <= wmask(reg_wdata, MASK_REC);
        OFF_GP: gp_reg <= wmask(reg_wdata, MASK_GP);
        OFF_PWRDN: pwrdn_reg <= wmask(reg_wdata, MASK_PWRDN);
        OFF_EXT: ext_reg <= wmask(reg_wdata, MASK_EXT);
        OFF_DAC_RATE: dac_rate_reg <= wmask(reg_wdata, MASK_RATE);
        OFF_ADC_RATE: adc_rate_reg <= wmask(reg_wdata, MASK_RATE);
        OFF_APWR: apwr_reg <= wmask(reg_wdata, MASK_APWR);
        OFF_ROUTE: route_reg <= wmask(reg_wdata, MASK_ROUTE);
        OFF_LVL_DAC: lvl_dac_reg <= wmask(reg_wdata, MASK_LVL_DAC);
        OFF_LVL_MODE: lvl_mode_reg <= wmask(reg_wdata, MASK_LVL_MODE);
        OFF_MIXVOL: mixvol_reg <= wmask(reg_wdata, MASK_MIXVOL);
        default: ;
      endcase
    end
  end

  // mic volume: host writes, and level control moves the pga field
  always_ff @(posedge clk_sys) begin
    if (rst || !pin_high_reg) begin
      mic_reg <= RST_MIC;
    end else if (reg_wr && reg_addr == OFF_MIC) begin
      mic_reg <= wmask(reg_wdata, MASK_MIC);
    end else if (lvl_apply) begin
      mic_reg[5:0] <= pga_target_reg;
    end
  end

  // level control
  assign lvl_en = lvl_mode_reg[B_LVL_EN];
  assign zc_off = lvl_mode_reg[B_ZCDIS];
  assign pga_now = mic_reg[5:0];
  assign ceiling = lvl_dac_reg[B_CEIL +: 6];
  assign lim_steps = 6'(lvl_mode_reg[B_LSTEP +: 2]) + 6'h01;
  assign wait_lim = 13'(WAIT_BASE_FS * 2) << lvl_mode_reg[B_WAIT +: 2];
  assign zc_lim = 13'(ZC_BASE_FS * 2) << lvl_mode_reg[B_ZCTO +: 2];
  assign per_lim = 4'h1 << lvl_mode_reg[B_LIM_PER +: 2];
  assign zc_to = (zc_cnt_reg >= zc_lim);
  // step then clip at the ceiling
  assign recov_next = step_up(pga_now, ceiling,
                              lvl_mode_reg[B_RSTEP]);
  assign lim_next = (pga_now > lim_steps) ? pga_now - lim_steps
                                          : 6'h00;
  assign lim_start = lvl_en && level_over && half_fs_tick
                     && (per_cnt_reg >= per_lim);
  assign recov_start = lvl_en && half_fs_tick
                       && (quiet_cnt_reg >= wait_lim);
  assign lvl_apply = (lvl_state_reg == LV_WAIT_ZC)
                     && (zc_off || zero_cross || zc_to);

  always_ff @(posedge clk_sys) begin
    if (rst || !lvl_en) begin
      lvl_state_reg <= LV_IDLE;
      pga_target_reg <= 6'h00;
      quiet_cnt_reg <= 13'h0000;
      zc_cnt_reg <= 13'h0000;
      per_cnt_reg <= 4'h0;
    end else begin
      if (half_fs_tick) begin
        quiet_cnt_reg <= level_over ? 13'h0000 : quiet_cnt_reg + 13'h0001;
        per_cnt_reg <= (per_cnt_reg >= per_lim) ? per_cnt_reg
                                                : per_cnt_reg + 4'h1;
        if (lvl_state_reg == LV_WAIT_ZC) begin
          zc_cnt_reg <= zc_cnt_reg + 13'h0001;
        end
      end
      unique case (lvl_state_reg)
        LV_IDLE: begin
          if (lim_start) begin
            pga_target_reg <= lim_next;
            // restart at one so the shortest period is one tick
            per_cnt_reg <= 4'h1;
            zc_cnt_reg <= 13'h0000;
            lvl_state_reg <= LV_WAIT_ZC;
          end else if (recov_start) begin
            pga_target_reg <= recov_next;
            quiet_cnt_reg <= 13'h0000;
            zc_cnt_reg <= 13'h0000;
            lvl_state_reg <= LV_WAIT_ZC;
          end
        end
        LV_WAIT_ZC: begin
          if (lvl_apply) begin
            lvl_state_reg <= LV_IDLE;
          end
        end
      endcase
    end
  end

  // readback; unmapped offsets read zero
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_addr)
      OFF_SPK: rd_mux = spk_reg;
      OFF_HP: rd_mux = hp_reg;
      OFF_MONO: rd_mux = mono_reg;
      OFF_BASS: rd_mux = bass_reg;
      OFF_BEEP: rd_mux = beep_reg;
      OFF_AUX: rd_mux = aux_reg;
      OFF_MIC: rd_mux = mic_reg;
      OFF_LINE: rd_mux = line_reg;
      OFF_DAC: rd_mux = dac_reg;
      OFF_REC: rd_mux = rec_reg;
      OFF_GP: rd_mux = gp_reg;
      OFF_PWRDN: rd_mux = pwrdn_reg | {12'h000, vref_ready, mixer_ready,
                                       dac_ready, adc_ready};
      OFF_EXT: rd_mux = ext_reg;
      OFF_DAC_RATE: rd_mux = dac_rate_reg;
      OFF_ADC_RATE: rd_mux = adc_rate_reg;
      OFF_APWR: rd_mux = apwr_reg;
      OFF_ROUTE: rd_mux = route_reg;
      OFF_LVL_DAC: rd_mux = lvl_dac_reg;
      OFF_LVL_MODE: rd_mux = lvl_mode_reg;
      OFF_MIXVOL: rd_mux = mixvol_reg;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // registered pin and control outputs
  logic spk_on, variable_rate_en;
  assign spk_on = apwr_reg[B_SPK_AMP];
  assign variable_rate_en = ext_reg[B_VRA];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      spk_pos_pin_oe <= 1'b0;
      spk_neg_pin_mid <= 1'b0;
      mono2_pin_oe <= 1'b0;
      mono2_pin_common_voltage <= 1'b0;
      irq_out_n <= 1'b1;
      dac_soft_silence <= 1'b0;
      dac_left_atten_eff <= 7'h00;
      dac_right_atten_eff <= 7'h00;
      beep_to_hp <= 1'b0;
      beep_to_spk <= 1'b0;
      int_mic_bias <= 1'b0;
      ext_mic_bias <= 1'b0;
      pll_power <= 1'b0;
      dac_rate_eff <= RST_RATE;
      adc_rate_eff <= RST_RATE;
      input_pga_level <= RST_MIC[5:0];
    end else begin
      // power-save only counts while the amp is powered
      spk_pos_pin_oe <= spk_on && !spk_reg[B_MUTE];
      spk_neg_pin_mid <= spk_on && spk_reg[B_MUTE];
      mono2_pin_oe <= spk_on;
      mono2_pin_common_voltage <= spk_on && !route_reg[B_MONO2];
      irq_out_n <= !(lvl_dac_reg[B_JACK_IRQ] && jack_seen_reg);
      dac_soft_silence <= dac_reg[B_MUTE];
      dac_left_atten_eff <= dac_reg[B_ATTL +: 7];
      dac_right_atten_eff <= lvl_dac_reg[B_LINK] ? dac_reg[B_ATTL +: 7]
                                                 : dac_reg[6:0];
      // beep power does not gate these paths
      beep_to_hp <= route_reg[B_BEEP_HP];
      beep_to_spk <= route_reg[B_BEEP_SPK];
      int_mic_bias <= apwr_reg[B_MIC_PWR] && apwr_reg[B_INT_BIAS];
      ext_mic_bias <= apwr_reg[B_MIC_PWR] && apwr_reg[B_EXT_BIAS];
      pll_power <= variable_rate_en;
      dac_rate_eff <= variable_rate_en ? dac_rate_reg : RST_RATE;
      adc_rate_eff <= variable_rate_en ? adc_rate_reg : RST_RATE;
      input_pga_level <= mic_reg[5:0];
    end
  end
endmodule // audio_codec_control_regs
`default_nettype wire

// file: hdl/codec_regs_pkg.sv
// package: register map, field layout, reset values and timing counts
package codec_regs_pkg;
  localparam logic [6:0] OFF_SPK = 7'h02;
  localparam logic [6:0] OFF_HP = 7'h04;
  localparam logic [6:0] OFF_MONO = 7'h06;
  localparam logic [6:0] OFF_BASS = 7'h08;
  localparam logic [6:0] OFF_BEEP = 7'h0A;
  localparam logic [6:0] OFF_AUX = 7'h0C;
  localparam logic [6:0] OFF_MIC = 7'h0E;
  localparam logic [6:0] OFF_LINE = 7'h10;
  localparam logic [6:0] OFF_DAC = 7'h18;
  localparam logic [6:0] OFF_REC = 7'h1A;
  localparam logic [6:0] OFF_GP = 7'h20;
  localparam logic [6:0] OFF_PWRDN = 7'h26;
  localparam logic [6:0] OFF_EXT = 7'h2A;
  localparam logic [6:0] OFF_DAC_RATE = 7'h2C;
  localparam logic [6:0] OFF_ADC_RATE = 7'h32;
  localparam logic [6:0] OFF_APWR = 7'h60;
  localparam logic [6:0] OFF_ROUTE = 7'h62;
  localparam logic [6:0] OFF_LVL_DAC = 7'h64;
  localparam logic [6:0] OFF_LVL_MODE = 7'h66;
  localparam logic [6:0] OFF_MIXVOL = 7'h68;
  // writable bit masks; all other bits read zero except the power-down ready flags
  localparam logic [15:0] MASK_SPK = 16'h8000;
  localparam logic [15:0] MASK_HP = 16'h8000;
  localparam logic [15:0] MASK_MONO = 16'h8007;
  localparam logic [15:0] MASK_BASS = 16'h0C00;
  localparam logic [15:0] MASK_BEEP = 16'h8000;
  localparam logic [15:0] MASK_AUX = 16'h801F;
  localparam logic [15:0] MASK_MIC = 16'h807F;
  localparam logic [15:0] MASK_LINE = 16'h9F1F;
  localparam logic [15:0] MASK_DAC = 16'hFF7F;
  localparam logic [15:0] MASK_REC = 16'h0300;
  localparam logic [15:0] MASK_GP = 16'h0380;
  localparam logic [15:0] MASK_PWRDN = 16'h7F00;
  localparam logic [15:0] MASK_EXT = 16'h0001;
  localparam logic [15:0] MASK_RATE = 16'hFFFF;
  localparam logic [15:0] MASK_APWR = 16'hC1FF;
  localparam logic [15:0] MASK_ROUTE = 16'h8FFF;
  localparam logic [15:0] MASK_LVL_DAC = 16'h7FFF;
  localparam logic [15:0] MASK_LVL_MODE = 16'h7F7F;
  localparam logic [15:0] MASK_MIXVOL = 16'h001F;
  // reset values
  localparam logic [15:0] RST_SPK = 16'h8000;
  localparam logic [15:0] RST_HP = 16'h8000;
  localparam logic [15:0] RST_MONO = 16'h8000;
  localparam logic [15:0] RST_BASS = 16'h0000;
  localparam logic [15:0] RST_BEEP = 16'h8000;
  localparam logic [15:0] RST_AUX = 16'h8008;
  localparam logic [15:0] RST_MIC = 16'h8008;
  localparam logic [15:0] RST_LINE = 16'h8808;
  localparam logic [15:0] RST_DAC = 16'h0000;
  localparam logic [15:0] RST_REC = 16'h0200;
  localparam logic [15:0] RST_GP = 16'h0000;
  localparam logic [15:0] RST_PWRDN = 16'h0300;
  localparam logic [15:0] RST_EXT = 16'h0000;
  localparam logic [15:0] RST_RATE = 16'hBB80;
  localparam logic [15:0] RST_APWR = 16'h0000;
  localparam logic [15:0] RST_ROUTE = 16'h0103;
  localparam logic [15:0] RST_LVL_DAC = 16'h2DA1;
  localparam logic [15:0] RST_LVL_MODE = 16'h0000;
  localparam logic [15:0] RST_MIXVOL = 16'h0002;
  // field positions
  localparam int B_MUTE = 15;
  localparam int B_BOOST = 6;
  localparam int B_ATTL = 8;
  localparam int B_VRA = 0;
  localparam int B_SPK_AMP = 7;
  localparam int B_BEEP_PWR = 4;
  localparam int B_MIC_PWR = 0;
  localparam int B_INT_BIAS = 14;
  localparam int B_EXT_BIAS = 15;
  localparam int B_MONO2 = 0;
  localparam int B_BEEP_SPK = 2;
  localparam int B_BEEP_HP = 3;
  localparam int B_LINK = 7;
  localparam int B_CEIL = 8;
  localparam int B_JACK_IRQ = 14;
  localparam int B_LIM_PER = 0;
  localparam int B_WAIT = 2;
  localparam int B_ZCTO = 4;
  localparam int B_RSTEP = 9;
  localparam int B_LSTEP = 10;
  localparam int B_ZCDIS = 12;
  localparam int B_LVL_EN = 13;
  // timing: half a sample period at 48 kHz
  localparam int CLK_HZ = 125000000;
  localparam int FS_HZ = 48000;
  localparam int FS_HALF_CYC = CLK_HZ / FS_HZ / 2;
  localparam int WAIT_BASE_FS = 128;
  localparam int ZC_BASE_FS = 128;
endpackage

// file: bench/codec_regs_assertions.sv
// checker: port-level properties of the codec control register bank
`timescale 1ns/10ps
`default_nettype none
module codec_regs_checker
  import codec_regs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_reset_n,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // pins and controls
  input wire logic jack_event,
  input wire logic spk_pos_pin_oe,
  input wire logic spk_neg_pin_mid,
  input wire logic irq_out_n,
  input wire logic pll_power,
  input wire logic [15:0] dac_rate_eff,
  input wire logic [15:0] adc_rate_eff,
  input wire logic [5:0] input_pga_level
);
  logic [3:0] quiet_reg;
  // host writes and pin resets move the gain legally, so wait them out
  always_ff @(posedge clk_sys) begin
    if (rst || reg_wr || !chip_reset_n)
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF)
      quiet_reg <= quiet_reg + 4'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_read_answer: assert property (
    reg_rd |=> reg_rvalid) else $error("read got no answer");
  a_no_stray: assert property (
    !reg_rd |=> !reg_rvalid) else $error("answer without read");
  a_rdata_held: assert property (
    disable iff (rst || !chip_reset_n)
    (!reg_rd && quiet_reg > 4'h5) |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_spk_pins_apart: assert property (
    !(spk_pos_pin_oe && spk_neg_pin_mid))
    else $error("speaker pins driven and held mid together");
  a_fixed_rate: assert property (
    !pll_power |-> (dac_rate_eff == RST_RATE && adc_rate_eff == RST_RATE))
    else $error("rate moved with pll off");
  a_irq_quiet: assert property (
    (!jack_event) [*8] |-> irq_out_n)
    else $error("interrupt low without jack event");
  a_limiter_fall: assert property (
    (quiet_reg > 4'h6 && input_pga_level < $past(input_pga_level))
    |-> ($past(input_pga_level) - input_pga_level) <= 6'd4)
    else $error("gain fell more than four steps");
  a_recovery_rise: assert property (
    (quiet_reg > 4'h6 && input_pga_level > $past(input_pga_level))
    |-> (input_pga_level - $past(input_pga_level)) inside {6'd1, 6'd2})
    else $error("gain rose by a wrong step");
endmodule // codec_regs_checker

bind audio_codec_control_regs codec_regs_checker i_chk (
  .clk_sys(clk_sys), .rst(rst), .chip_reset_n(chip_reset_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .jack_event(jack_event),
  .spk_pos_pin_oe(spk_pos_pin_oe), .spk_neg_pin_mid(spk_neg_pin_mid),
  .irq_out_n(irq_out_n), .pll_power(pll_power),
  .dac_rate_eff(dac_rate_eff), .adc_rate_eff(adc_rate_eff),
  .input_pga_level(input_pga_level));
`default_nettype wire

// file: bench/codec_host_model.sv
// host controller model driving register reads and writes
`timescale 1ns/10ps
`default_nettype none
module codec_host_model
  import codec_regs_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // register access
  output logic reg_wr,
  output logic reg_rd,
  output logic [6:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  logic loop_on;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
    loop_on = 1'b0;
  end
  // one write, then time for the derived outputs to follow
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] w;
    w = d;
    if (a == OFF_EXT && loop_on)
      w[B_VRA] = 1'b0;
    if (a == OFF_GP)
      loop_on = d[7];
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // a released bus shows junk, never the old value
    reg_addr <= ~a;
    reg_wdata <= ~w;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    logic got;
    got = 1'b0;
    v = 'x;
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (int k = 0; k < 4 && !got; k++) begin
      @(negedge clk_sys);
      got = reg_rvalid;
      if (got)
        v = reg_rdata;
    end
  endtask
endmodule // codec_host_model
`default_nettype wire

// file: bench/test_audio_codec_control_regs.sv
// testbench for the codec control register bank
`timescale 1ns/10ps
`default_nettype none
module test_audio_codec_control_regs;
  import codec_regs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic chip_reset_n = 1'b0;
  logic [3:0] stat = 4'h0;
  logic jack_event = 1'b0;
  logic level_over = 1'b0;
  logic zero_cross = 1'b0;
  logic reg_wr, reg_rd, reg_rvalid, spo, snm, m2oe, m2cv, irq_n;
  logic silence, b_hp, b_spk, ibias, ebias, pll;
  logic [6:0] reg_addr, att_l, att_r;
  logic [15:0] reg_wdata, reg_rdata, dre, are, v;
  logic [5:0] pga;
  int miscompares = 0;
  int comparisons = 0;
  logic [6:0] offs [20] = '{OFF_SPK, OFF_HP, OFF_MONO, OFF_BASS, OFF_BEEP,
    OFF_AUX, OFF_MIC, OFF_LINE, OFF_DAC, OFF_REC, OFF_GP, OFF_PWRDN,
    OFF_EXT, OFF_DAC_RATE, OFF_ADC_RATE, OFF_APWR, OFF_ROUTE,
    OFF_LVL_DAC, OFF_LVL_MODE, OFF_MIXVOL};
  logic [15:0] rsts [20] = '{RST_SPK, RST_HP, RST_MONO, RST_BASS, RST_BEEP,
    RST_AUX, RST_MIC, RST_LINE, RST_DAC, RST_REC, RST_GP, RST_PWRDN,
    RST_EXT, RST_RATE, RST_RATE, RST_APWR, RST_ROUTE, RST_LVL_DAC,
    RST_LVL_MODE, RST_MIXVOL};
  logic [15:0] msks [20] = '{MASK_SPK, MASK_HP, MASK_MONO, MASK_BASS,
    MASK_BEEP, MASK_AUX, MASK_MIC, MASK_LINE, MASK_DAC, MASK_REC, MASK_GP,
    MASK_PWRDN, MASK_EXT, MASK_RATE, MASK_RATE, MASK_APWR, MASK_ROUTE,
    MASK_LVL_DAC, MASK_LVL_MODE, MASK_MIXVOL};
  always #4 clk_sys = ~clk_sys;
  audio_codec_control_regs i_dut (
    .clk_sys(clk_sys), .rst(rst), .chip_reset_n(chip_reset_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .vref_ready(stat[3]), .mixer_ready(stat[2]), .dac_ready(stat[1]),
    .adc_ready(stat[0]), .jack_event(jack_event),
    .level_over(level_over), .zero_cross(zero_cross),
    .spk_pos_pin_oe(spo), .spk_neg_pin_mid(snm), .mono2_pin_oe(m2oe),
    .mono2_pin_common_voltage(m2cv), .irq_out_n(irq_n),
    .dac_soft_silence(silence), .dac_left_atten_eff(att_l),
    .dac_right_atten_eff(att_r), .beep_to_hp(b_hp), .beep_to_spk(b_spk),
    .int_mic_bias(ibias), .ext_mic_bias(ebias), .pll_power(pll),
    .dac_rate_eff(dre), .adc_rate_eff(are), .input_pga_level(pga));
  codec_host_model i_host (
    .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for the gain to leave a value
  task automatic wait_pga(input logic [5:0] old);
    for (int k = 0; k < 8000 && pga === old; k++)
      @(posedge clk_sys);
    #1;
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    chip_reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 20; i++) begin
      i_host.rd(offs[i], v);
      chk(v, rsts[i]);
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      stat <= 4'h8 >> i;
      i_host.rd(OFF_PWRDN, v);
      chk(v, RST_PWRDN | (16'h0008 >> i));
    end
    @(posedge clk_sys);
    stat <= 4'h0;
    // variable rate stays off here so loopback may be set
    for (int i = 0; i < 20; i++) begin
      if (offs[i] != OFF_EXT) begin
        i_host.wr(offs[i], 16'hFFFF);
        i_host.rd(offs[i], v);
        chk(v, (offs[i] == OFF_DAC) ? 16'hFF00 : msks[i]);
      end
    end
    i_host.wr(7'h22, 16'hFFFF);
    i_host.rd(7'h22, v);
    chk(v, 16'h0000);
    chk(silence, 1'b1);
    chk({spo, snm, m2oe, m2cv}, 4'b0110);
    chk({ibias, ebias, pll}, 3'b110);
    chk(dre, RST_RATE);
    i_host.wr(OFF_GP, 16'h0000);
    i_host.wr(OFF_EXT, 16'h0001);
    chk({15'h0000, pll}, 16'h0001);
    chk(dre, 16'hFFFF);
    chk(are, 16'hFFFF);
    i_host.wr(OFF_APWR, 16'hC000);
    chk({b_hp, b_spk, ibias, ebias}, 4'b1100);
    chk({spo, snm, m2oe}, 3'b000);
    i_host.wr(OFF_ROUTE, 16'h0000);
    chk({b_hp, b_spk}, 2'b00);
    i_host.wr(OFF_SPK, 16'h0000);
    i_host.wr(OFF_APWR, 16'h0080);
    chk({spo, snm, m2oe, m2cv}, 4'b1011);
    @(posedge clk_sys);
    chip_reset_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    chip_reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    i_host.rd(OFF_APWR, v);
    chk(v, 16'h0000);
    i_host.wr(OFF_LVL_DAC, 16'h0000);
    i_host.wr(OFF_DAC, 16'h0305);
    chk({att_l, att_r}, 16'h0185);
    i_host.wr(OFF_LVL_DAC, 16'h0080);
    i_host.wr(OFF_DAC, 16'h0A07);
    chk(att_r, 7'h0A);
    i_host.rd(OFF_DAC, v);
    chk(v, 16'h0A05);
    i_host.wr(OFF_LVL_DAC, 16'h4000);
    @(posedge clk_sys);
    jack_event <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(irq_n, 1'b0);
    i_host.wr(OFF_LVL_DAC, 16'h0000);
    chk(irq_n, 1'b1);
    @(posedge clk_sys);
    jack_event <= 1'b0;
    i_host.wr(OFF_MIC, 16'h0007);
    // immediate mode, four steps a limiter event
    i_host.wr(OFF_LVL_MODE, 16'h3C00);
    @(posedge clk_sys);
    level_over <= 1'b1;
    wait_pga(6'h07);
    chk(pga, 6'h03);
    wait_pga(6'h03);
    chk(pga, 6'h00);
    @(posedge clk_sys);
    level_over <= 1'b0;
    // zero-cross mode holds the new gain until a crossing
    i_host.wr(OFF_LVL_MODE, 16'h0000);
    i_host.wr(OFF_MIC, 16'h0010);
    i_host.wr(OFF_LVL_MODE, 16'h2000);
    @(posedge clk_sys);
    level_over <= 1'b1;
    repeat (4000) @(posedge clk_sys);
    #1;
    chk(pga, 6'h10);
    @(posedge clk_sys);
    zero_cross <= 1'b1;
    wait_pga(6'h10);
    chk(pga, 6'h0F);
    @(posedge clk_sys);
    zero_cross <= 1'b0;
    level_over <= 1'b0;
    wrap_up();
  end
endmodule // test_audio_codec_control_regs
`default_nettype wire
